// File: design/fmt_map.svh
// What this block does
// - Start nibble 1101 with frame low begins a firmware memory read.
// - Start nibble 1110 with frame low begins a firmware memory write.
// - Only the nibble seen in the last frame-low clock is the start value.
// - Clock two select nibble must equal the four strap inputs exactly.
// - Clocks three to nine carry seven address nibbles, most significant first.
// - Clock ten size nibble must be 0000; only single bytes are moved.
// - Device starts driving in clock twelve for reads, fourteen for writes.
// - In reads the device drives ready sync 0000 in clock thirteen.
// - Read byte goes out in clocks fourteen and fifteen, low nibble first.
// - After read data the device drives 1111 in sixteen, floats before seventeen.
// - Write byte arrives in clocks eleven and twelve, low nibble first.
// - In writes host turns round in thirteen; device sends sync 0000 in fifteen.
// - Device drives 1111 and floats in sixteen; host owns bus in seventeen.
// - Every field nibble is sampled on the rising edge ending its clock.
//
// Purpose: constants of the firmware memory cycle target.
// Assumes: one clock, all inputs synchronous.
// Notes:   definitions only.
`ifndef FMT_MAP_SVH
`define FMT_MAP_SVH

// ==========================================================
// field codes
`define FMT_START_RD   4'hD
`define FMT_START_WR   4'hE
`define FMT_SIZE_ONE   4'h0
`define FMT_SYNC_READY 4'h0
`define FMT_TAR_NIBBLE 4'hF

// ==========================================================
// field layout
`define FMT_NIB_W      4
`define FMT_ADDR_W     28
`define FMT_DATA_W     8
`define FMT_CNT_W      3
`define FMT_ADDR_LAST  3'h6

`endif

// File: design/fmt_pkg.sv
// Purpose: types of the firmware memory cycle target.
// Assumes: fmt_map.svh gives the widths.
// Notes:   no constants live here.
`include "fmt_map.svh"

package fmt_pkg;

  // ==========================================================
  // bus field states, named after what the lines carry
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SIZE,
    ST_WLO,
    ST_WHI,
    ST_HOST_TAR,
    ST_DEV_TAR,
    ST_SYNC,
    ST_RLO,
    ST_RHI,
    ST_DEV_END
  } fmt_state_t;

  // ==========================================================
  // memory request towards the array
  typedef struct packed {
    logic                   valid;
    logic                   write;
    logic [`FMT_ADDR_W-1:0] addr;
    logic [`FMT_DATA_W-1:0] wdata;
  } fmt_req_t;

endpackage : fmt_pkg

// File: design/fmt_target.sv
// Purpose: target side of single-byte firmware memory cycles.
// Assumes: rd_data valid in the clock after a read request pulse.
// Notes:   lad_oe_n low means this block drives the lines.
`timescale 1ns/1ps
`include "fmt_map.svh"

module fmt_target (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   frame_n,
  input  wire logic [`FMT_NIB_W-1:0]  lad_in,
  output logic      [`FMT_NIB_W-1:0]  lad_out,
  output logic                        lad_oe_n,
  input  wire logic [`FMT_NIB_W-1:0]  select_strap_inputs,
  output fmt_pkg::fmt_req_t           mem_req,
  input  wire logic [`FMT_DATA_W-1:0] rd_data,
  output logic                        cycle_ignored
);

  // ==========================================================
  // state
  fmt_pkg::fmt_state_t    st_q;
  fmt_pkg::fmt_state_t    st_d;
  logic [`FMT_CNT_W-1:0]  cnt_q;
  logic [`FMT_CNT_W-1:0]  cnt_d;
  logic                   armed_q;
  logic                   armed_d;
  logic [`FMT_NIB_W-1:0]  start_q;
  logic [`FMT_NIB_W-1:0]  start_d;
  logic                   wr_q;
  logic                   wr_d;
  logic [`FMT_ADDR_W-1:0] addr_q;
  logic [`FMT_ADDR_W-1:0] addr_d;
  logic [`FMT_DATA_W-1:0] wdata_q;
  logic [`FMT_DATA_W-1:0] wdata_d;
  logic [`FMT_DATA_W-1:0] rdata_q;
  logic [`FMT_DATA_W-1:0] rdata_d;
  logic [`FMT_NIB_W-1:0]  out_q;
  logic [`FMT_NIB_W-1:0]  out_d;
  logic                   oe_n_q;
  logic                   oe_n_d;
  fmt_pkg::fmt_req_t      req_q;
  fmt_pkg::fmt_req_t      req_d;
  logic                   ign_q;
  logic                   ign_d;

  logic                   start_known;
  logic                   select_hit;

  assign start_known = (start_q == `FMT_START_RD) || (start_q == `FMT_START_WR);
  assign select_hit  = (lad_in == select_strap_inputs);

  // ==========================================================
  // next state
  always_comb begin
    st_d          = st_q;
    cnt_d         = cnt_q;
    armed_d       = armed_q;
    start_d       = start_q;
    wr_d          = wr_q;
    addr_d        = addr_q;
    wdata_d       = wdata_q;
    rdata_d       = rdata_q;
    out_d         = `FMT_TAR_NIBBLE;
    oe_n_d        = 1'b1;
    req_d         = req_q;
    req_d.valid   = 1'b0;
    ign_d         = 1'b0;
    // last frame-low nibble wins
    // frame low anywhere also drops a cycle in progress and frees the lines
    if (!frame_n) begin
      st_d    = fmt_pkg::ST_IDLE;
      armed_d = 1'b1;
      start_d = lad_in;
    end else begin
      unique case (st_q)
        fmt_pkg::ST_IDLE: begin
          if (armed_q) begin
            armed_d = 1'b0;
            if (start_known && select_hit) begin
              st_d  = fmt_pkg::ST_ADDR;
              cnt_d = '0;
              wr_d  = (start_q == `FMT_START_WR);
            end else begin
              ign_d = start_known;
            end
          end
        end
        fmt_pkg::ST_ADDR: begin
          addr_d = {addr_q[`FMT_ADDR_W-`FMT_NIB_W-1:0], lad_in};
          cnt_d  = cnt_q + 1'b1;
          if (cnt_q == `FMT_ADDR_LAST) begin
            st_d = fmt_pkg::ST_SIZE;
          end
        end
        fmt_pkg::ST_SIZE: begin
          // only one byte; other sizes end the cycle and pulse cycle_ignored
          if (lad_in != `FMT_SIZE_ONE) begin
            st_d  = fmt_pkg::ST_IDLE;
            ign_d = 1'b1;
          end else if (wr_q) begin
            st_d = fmt_pkg::ST_WLO;
          end else begin
            st_d          = fmt_pkg::ST_HOST_TAR;
            req_d.valid   = 1'b1;
            req_d.write   = 1'b0;
            req_d.addr    = addr_q;
          end
        end
        fmt_pkg::ST_WLO: begin
          wdata_d[3:0] = lad_in;
          st_d         = fmt_pkg::ST_WHI;
        end
        fmt_pkg::ST_WHI: begin
          wdata_d[7:4]  = lad_in;
          st_d          = fmt_pkg::ST_HOST_TAR;
          req_d.valid   = 1'b1;
          req_d.write   = 1'b1;
          req_d.addr    = addr_q;
          req_d.wdata   = {lad_in, wdata_q[3:0]};
        end
        fmt_pkg::ST_HOST_TAR: begin
          // take the lines in the second turnaround clock
          st_d   = fmt_pkg::ST_DEV_TAR;
          oe_n_d = 1'b0;
        end
        fmt_pkg::ST_DEV_TAR: begin
          st_d   = fmt_pkg::ST_SYNC;
          oe_n_d = 1'b0;
          out_d  = `FMT_SYNC_READY;
          if (!wr_q) begin
            rdata_d = rd_data;
          end
        end
        fmt_pkg::ST_SYNC: begin
          oe_n_d = 1'b0;
          if (wr_q) begin
            st_d = fmt_pkg::ST_DEV_END;
          end else begin
            st_d  = fmt_pkg::ST_RLO;
            out_d = rdata_q[3:0];
          end
        end
        fmt_pkg::ST_RLO: begin
          st_d   = fmt_pkg::ST_RHI;
          oe_n_d = 1'b0;
          out_d  = rdata_q[7:4];
        end
        fmt_pkg::ST_RHI: begin
          st_d   = fmt_pkg::ST_DEV_END;
          oe_n_d = 1'b0;
        end
        fmt_pkg::ST_DEV_END: begin
          // float so the host owns clock seventeen
          st_d = fmt_pkg::ST_IDLE;
        end
        default: begin
          st_d = fmt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  // every field sampled on the edge ending its clock
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q    <= fmt_pkg::ST_IDLE;
      cnt_q   <= '0;
      armed_q <= 1'b0;
      start_q <= '0;
      wr_q    <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      out_q   <= `FMT_TAR_NIBBLE;
      oe_n_q  <= 1'b1;
      req_q   <= '0;
      ign_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      armed_q <= armed_d;
      start_q <= start_d;
      wr_q    <= wr_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      out_q   <= out_d;
      oe_n_q  <= oe_n_d;
      req_q   <= req_d;
      ign_q   <= ign_d;
    end
  end

  assign lad_out       = out_q;
  assign lad_oe_n      = oe_n_q;
  assign mem_req       = req_q;
  assign cycle_ignored = ign_q;

  // ==========================================================
  // checks
  sequence s_dev_take;
    $fell(oe_n_q) && (out_q == `FMT_TAR_NIBBLE);
  endsequence

  sequence s_ready;
    !oe_n_q && (out_q == `FMT_SYNC_READY);
  endsequence

  sequence s_sel_read;
    (st_q == fmt_pkg::ST_IDLE) && armed_q && frame_n && select_hit && (start_q == `FMT_START_RD);
  endsequence

  sequence s_sel_write;
    (st_q == fmt_pkg::ST_IDLE) && armed_q && frame_n && select_hit && (start_q == `FMT_START_WR);
  endsequence

  AST_START_READ: assert property (@(posedge clk) disable iff (srst)
    s_sel_read |=> (st_q == fmt_pkg::ST_ADDR) && !wr_q)
    else $error("read start not taken");

  AST_START_WRITE: assert property (@(posedge clk) disable iff (srst)
    s_sel_write |=> (st_q == fmt_pkg::ST_ADDR) && wr_q)
    else $error("write start not taken");

  // start latched from last low clock
  AST_LAST_START: assert property (@(posedge clk) disable iff (srst)
    (!frame_n ##1 frame_n) |-> (start_q == $past(lad_in)) && armed_q)
    else $error("start value not the last frame-low nibble");

  AST_NO_DRIVE_MISS: assert property (@(posedge clk) disable iff (srst || !frame_n)
    ((st_q == fmt_pkg::ST_IDLE) && armed_q && frame_n && !select_hit) |=> oe_n_q [*8])
    else $error("drive after select mismatch");

  AST_ADDR_ORDER: assert property (@(posedge clk) disable iff (srst || !frame_n)
    ((st_q == fmt_pkg::ST_ADDR) && (cnt_q == `FMT_ADDR_LAST))
      |=> (addr_q[3:0] == $past(lad_in)) && (addr_q[7:4] == $past(lad_in, 2)))
    else $error("address nibbles out of order");

  AST_READ_TAKE: assert property (@(posedge clk) disable iff (srst || !frame_n)
    ((st_q == fmt_pkg::ST_HOST_TAR) && !wr_q) |=> s_dev_take ##1 s_ready)
    else $error("read turnaround or sync wrong");

  AST_WRITE_TAKE: assert property (@(posedge clk) disable iff (srst || !frame_n)
    ((st_q == fmt_pkg::ST_WHI) && wr_q) |=> oe_n_q ##1 s_dev_take ##1 s_ready)
    else $error("write turnaround or sync wrong");

  AST_READ_DATA: assert property (@(posedge clk) disable iff (srst || !frame_n)
    (st_q == fmt_pkg::ST_RLO) |-> (out_q == rdata_q[3:0]) ##1 (out_q == rdata_q[7:4])
      ##1 (!oe_n_q && (out_q == `FMT_TAR_NIBBLE)) ##1 oe_n_q)
    else $error("read data or release wrong");

  AST_WDATA: assert property (@(posedge clk) disable iff (srst || !frame_n)
    (st_q == fmt_pkg::ST_WHI)
      |=> mem_req.valid && mem_req.write && (mem_req.wdata == {$past(lad_in), $past(lad_in, 2)}))
    else $error("write byte wrong");

  AST_END_FLOAT: assert property (@(posedge clk) disable iff (srst)
    (st_q == fmt_pkg::ST_DEV_END) |-> !oe_n_q && (out_q == `FMT_TAR_NIBBLE) ##1 oe_n_q)
    else $error("lines not released");

  AST_SIZE_BAD: assert property (@(posedge clk) disable iff (srst || !frame_n)
    ((st_q == fmt_pkg::ST_SIZE) && (lad_in != `FMT_SIZE_ONE)) |=> cycle_ignored ##0 oe_n_q [*4])
    else $error("unsupported size accepted");

  AST_SELECT_MISS: assert property (@(posedge clk) disable iff (srst)
    ((st_q == fmt_pkg::ST_IDLE) && armed_q && frame_n && start_known && !select_hit)
      |=> (st_q == fmt_pkg::ST_IDLE) && cycle_ignored && oe_n_q)
    else $error("select mismatch taken");

  AST_START_UNKNOWN: assert property (@(posedge clk) disable iff (srst)
    ((st_q == fmt_pkg::ST_IDLE) && armed_q && frame_n && !start_known)
      |=> (st_q == fmt_pkg::ST_IDLE) && !cycle_ignored && oe_n_q)
    else $error("unknown start not ignored");

  AST_READ_REQ: assert property (@(posedge clk) disable iff (srst || !frame_n)
    ((st_q == fmt_pkg::ST_SIZE) && (lad_in == `FMT_SIZE_ONE) && !wr_q)
      |=> mem_req.valid && !mem_req.write && (mem_req.addr == $past(addr_q)))
    else $error("read request wrong");

  // read byte taken while the array answers
  AST_READ_SAMPLE: assert property (@(posedge clk) disable iff (srst || !frame_n)
    ((st_q == fmt_pkg::ST_DEV_TAR) && !wr_q) |=> (rdata_q == $past(rd_data)))
    else $error("read byte sampled in the wrong clock");

  AST_REQ_PULSE: assert property (@(posedge clk) disable iff (srst)
    mem_req.valid |=> !mem_req.valid)
    else $error("request longer than one clock");

endmodule // fmt_target

// File: tb/fmt_host_model.sv
// Purpose: host chipset model that drives firmware memory cycles.
// Assumes: lines pulled up to 1111 while nobody drives them.
// Notes:   keeps the lines and enable of clocks 1 to 17 of the last cycle, and of clock 0 only after a decoy start.
`timescale 1ns/1ps
`include "fmt_map.svh"

module fmt_host_model (
  input  wire logic                  clk,
  input  wire logic [`FMT_NIB_W-1:0] lad_in,
  input  wire logic                  lad_oe_n,
  output logic                       frame_n,
  output logic      [`FMT_NIB_W-1:0] host_lad,
  output logic                       host_oe
);
  logic [`FMT_NIB_W-1:0] cap_lad [0:17];
  logic                  cap_oe  [0:17];

  initial begin
    frame_n  = 1'b1;
    host_lad = 4'hF;
    host_oe  = 1'b1;
  end

  // ==========================================================
  // one cycle; clocks before clock 1 keep frame low with a decoy start
  task automatic run(input logic [3:0] start, input logic [3:0] sel, input logic [27:0] addr,
                     input logic [3:0] size, input logic [7:0] wdata, input int pre);
    logic [3:0] nib;
    logic       wr;
    wr = (start == `FMT_START_WR);
    for (int k = 1 - pre; k <= 17; k++) begin
      case (k)
        2:       nib = sel;
        10:      nib = size;
        11:      nib = wr ? wdata[3:0] : `FMT_TAR_NIBBLE;
        12:      nib = wdata[7:4];
        default: nib = (k >= 3 && k <= 9) ? addr[4*(9-k) +: 4] : (k == 1) ? start : (k < 1) ? start ^ 4'h3 : 4'hF;
      endcase
      @(posedge clk);
      // frame low only up to clock 1
      frame_n  <= (k > 1);
      host_lad <= nib;
      // host floats after its turnaround, back in 17
      host_oe  <= (k <= (wr ? 13 : 11)) || (k == 17);
      @(negedge clk);
      if (k >= 0) begin
        cap_lad[k] = lad_in;
        cap_oe[k]  = lad_oe_n;
      end
    end
  endtask
endmodule // fmt_host_model

// File: tb/tb_lpc_firmware_memory_cycle_target.sv
// Purpose: self-checking bench of the firmware memory cycle target.
// Assumes: memory byte follows the address, valid a clock after it.
// Notes:   random cycles, seed 68, with corner cases first.
`timescale 1ns/1ps
`include "fmt_map.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end

module tb_lpc_firmware_memory_cycle_target;
  logic              clk, srst, frame_n, host_oe, lad_oe_n, cycle_ignored;
  logic [3:0]        host_lad, lad_in, lad_out, strap;
  logic [7:0]        rd_data;
  fmt_pkg::fmt_req_t mem_req, last_req;
  int                err_total, checked, n_req, n_ign;

  // pull-ups win when nobody drives
  assign lad_in = !lad_oe_n ? lad_out : host_oe ? host_lad : 4'hF;

  fmt_target u_dut (.clk(clk), .srst(srst), .frame_n(frame_n), .lad_in(lad_in), .lad_out(lad_out),
    .lad_oe_n(lad_oe_n), .select_strap_inputs(strap), .mem_req(mem_req), .rd_data(rd_data),
    .cycle_ignored(cycle_ignored));
  fmt_host_model u_host (.clk(clk), .lad_in(lad_in), .lad_oe_n(lad_oe_n), .frame_n(frame_n),
    .host_lad(host_lad), .host_oe(host_oe));

  function automatic logic [7:0] mem_byte(input logic [27:0] a);
    return a[7:0] ^ a[27:20];
  endfunction
  function automatic logic exp_oe(input int k, input logic rd, input logic wr);
    return !((rd && k >= 12 && k <= 16) || (wr && k >= 14 && k <= 16));
  endfunction
  function automatic logic [3:0] exp_lad(input int k, input logic wr, input logic [7:0] b);
    if (k == 13 || (k == 15 && wr)) return 4'h0;
    if (k == 14 && !wr) return b[3:0];
    if (k == 15) return b[7:4];
    return 4'hF;
  endfunction

  initial begin
    rd_data = 8'h00;
    // array answers only in the clock after a request, so a late sample reads garbage
    forever @(posedge clk) rd_data <= mem_req.valid ? mem_byte(mem_req.addr) : ~mem_byte(mem_req.addr);
  end
  always @(negedge clk) begin
    if (mem_req.valid === 1'b1) begin
      n_req++;
      last_req = mem_req;
    end
    if (cycle_ignored === 1'b1) n_ign++;
    if (lad_oe_n === 1'b0) `CHK(host_oe, 1'b0)
  end

  task automatic cyc(input logic [3:0] start, input logic [3:0] st, input logic [3:0] sel,
                     input logic [27:0] a, input logic [3:0] size, input logic [7:0] wd, input int pre);
    logic known, ok, wr;
    known = start == `FMT_START_RD || start == `FMT_START_WR;
    ok    = known && sel == st && size == `FMT_SIZE_ONE;
    wr    = ok && start == `FMT_START_WR;
    @(posedge clk) strap <= st;
    n_req = 0;
    n_ign = 0;
    u_host.run(start, sel, a, size, wd, pre);
    `CHK(n_req, ok ? 1 : 0)
    `CHK(n_ign, (known && !ok) ? 1 : 0)
    if (ok) begin
      `CHK(last_req.write, wr)
      `CHK(last_req.addr, a)
      if (wr) `CHK(last_req.wdata, wd)
    end
    // clock 0 is captured only when a decoy start ran before the real one
    for (int k = (pre > 0) ? 0 : 1; k <= 17; k++) begin
      `CHK(u_host.cap_oe[k], exp_oe(k, ok && !wr, wr))
      if (u_host.cap_oe[k] === 1'b0) `CHK(u_host.cap_lad[k], exp_lad(k, wr, mem_byte(a)))
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #(100 * 4000);
    err_total++;
    $display("unexpected t=%0t watchdog", $time);
    tally_and_finish();
  end

  initial begin
    logic [3:0] st;
    int         r;
    srst = 1'b1;
    strap = 4'h5;
    err_total = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    void'($urandom(68));
    cyc(`FMT_START_RD, 4'h5, 4'h5, 28'h0000000, 4'h0, 8'h00, 0);
    cyc(`FMT_START_WR, 4'hA, 4'hA, 28'hFFFFFFF, 4'h0, 8'hA5, 0);
    cyc(`FMT_START_WR, 4'h3, 4'h3, 28'h1234567, 4'h0, 8'h3C, 3);
    cyc(`FMT_START_RD, 4'hF, 4'hF, 28'h89ABCDE, 4'h0, 8'h00, 2);
    cyc(4'h0, 4'h0, 4'h0, 28'h0000010, 4'h0, 8'h00, 0);
    cyc(`FMT_START_RD, 4'h6, 4'h7, 28'h0000020, 4'h0, 8'h00, 0);
    cyc(`FMT_START_WR, 4'h9, 4'h9, 28'h0000030, 4'h1, 8'h11, 0);
    $display("directed test done");
    // reset while read data is on the lines must free them at once
    @(posedge clk) strap <= 4'h5;
    fork
      u_host.run(`FMT_START_RD, 4'h5, 28'h0000040, 4'h0, 8'h00, 0);
      begin
        repeat (14) @(posedge clk);
        srst <= 1'b1;
        @(posedge clk) srst <= 1'b0;
      end
    join
    `CHK(u_host.cap_oe[14], 1'b0)
    `CHK(u_host.cap_oe[15], 1'b1)
    `CHK(u_host.cap_oe[16], 1'b1)
    `CHK(mem_req, '0)
    $display("reset test done");
    for (int i = 0; i < 60; i++) begin
      r  = $urandom % 8;
      st = 4'($urandom);
      cyc(r < 3 ? `FMT_START_RD : r < 6 ? `FMT_START_WR : 4'($urandom), st,
          ($urandom % 5 == 0) ? st ^ 4'($urandom) : st, 28'($urandom),
          ($urandom % 6 == 0) ? 4'($urandom) : 4'h0, 8'($urandom), int'($urandom % 3));
    end
    $display("random test done");
    tally_and_finish();
  end
endmodule // tb_lpc_firmware_memory_cycle_target
